//--- core/dcie_completion_irq.sv
`timescale 1ns/1ps
`default_nettype none

module dcie_completion_irq #(
  parameter int NUM_REGIONS = 8,
  parameter int NUM_QCH     = 4
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire dcie_pkg::dcie_bus_req_s busReq,
  output logic [dcie_pkg::DATA_W-1:0]  busRdata,
  input  wire dcie_pkg::dcie_tcc_s     transfer_completion_code,
  output logic [NUM_QCH-1:0]           quickChannelEnable,
  output logic                         globalCompletionIrq,
  output logic [NUM_REGIONS-1:0]       regionCompletionIrq,
  output logic                         irqOut
);

  localparam int W   = dcie_pkg::DATA_W;
  localparam int NC  = dcie_pkg::NUM_CODES;
  localparam int RW  = dcie_pkg::REGION_W;
  localparam int OW  = dcie_pkg::OFF_W;
  localparam int SW  = dcie_pkg::STATUS_W;
  localparam int AS  = dcie_pkg::ACC_SHIFT;
  localparam int NR1 = NUM_REGIONS + 1;

  logic [RW-1:0]    regionField;
  logic [OW-1:0]    offset;
  logic [RW-1:0]    shadowIdx;
  logic             isGlobal;
  logic             isShadow;
  logic             inRange;

  logic [NC-1:0]    pending;
  logic [NC-1:0]    enable;
  logic [NUM_REGIONS-1:0][NC-1:0]      dmaAccess;
  logic [NUM_REGIONS-1:0][NUM_QCH-1:0] quickAccess;
  logic [SW-1:0]    status;
  logic [SW-1:0]    mask;

  logic [NC-1:0]    dmaView;
  logic [NUM_QCH-1:0] quickView;
  logic [W-1:0]     viewLo;
  logic [W-1:0]     viewHi;

  logic             wrEnLo;
  logic             wrEnHi;
  logic             wrClrLo;
  logic             wrClrHi;
  logic             wrQuick;
  logic             wrStatus;
  logic             wrMask;
  logic             evalWrite;

  logic [OW-1:0]    accOffset;
  logic [OW-AS-1:0] accRegion;
  logic [AS-1:0]    accSub;
  logic             accHit;

  logic [NC-1:0]    setVec;
  logic [NC-1:0]    clrVec;
  logic [W-1:0]     pendLo;
  logic [W-1:0]     pendHi;
  logic [NR1-1:0]   evalSel;
  logic [NR1-1:0]   pendEnabled;
  logic [NR1-1:0]   pendAny;
  logic [NR1-1:0]   irqPulse;
  logic [SW-1:0]    events;
  logic [SW-1:0]    statusClr;
  logic [W-1:0]     readWord;

  // address decode: upper field picks the region, low byte the register
  assign regionField = busReq.addr[dcie_pkg::ADDR_W-1:OW];
  assign offset      = busReq.addr[OW-1:0];
  assign shadowIdx   = regionField - dcie_pkg::SHADOW_FIRST;
  assign isGlobal    = (regionField == dcie_pkg::GLOBAL_REGION);
  assign isShadow    = !isGlobal && (regionField <= RW'(NUM_REGIONS));
  assign inRange     = isGlobal || isShadow;

  // what the accessing region may touch; global sees everything
  always_comb begin
    dmaView   = isGlobal ? '1 : '0;
    quickView = isGlobal ? '1 : '0;
    for (int r = 0; r < NUM_REGIONS; r++) begin
      if (isShadow && (shadowIdx == RW'(r))) begin
        dmaView   = dmaAccess[r];
        quickView = quickAccess[r];
      end
    end
  end

  assign viewLo = dmaView[W-1:0];
  assign viewHi = dmaView[NC-1:W];

  assign wrEnLo   = busReq.wr && inRange && (offset == dcie_pkg::OFF_EN_LO);
  assign wrEnHi   = busReq.wr && inRange && (offset == dcie_pkg::OFF_EN_HI);
  assign wrClrLo  = busReq.wr && inRange && (offset == dcie_pkg::OFF_CLR_LO);
  assign wrClrHi  = busReq.wr && inRange && (offset == dcie_pkg::OFF_CLR_HI);
  assign wrQuick  = busReq.wr && inRange
                    && (offset == dcie_pkg::OFF_QUICK_EN);
  assign wrStatus = busReq.wr && isGlobal
                    && (offset == dcie_pkg::OFF_IRQ_STATUS);
  assign wrMask   = busReq.wr && isGlobal
                    && (offset == dcie_pkg::OFF_IRQ_MASK);

  // no access mask here: every copy of the evaluate register is live
  assign evalWrite = busReq.wr && inRange
                     && (offset == dcie_pkg::OFF_REEVAL)
                     && busReq.wdata[dcie_pkg::REEVALUATE_TRIGGER_BIT_BIT];

  // access enables live in the global range only
  assign accOffset = offset - dcie_pkg::OFF_ACCESS;
  assign accRegion = accOffset[OW-1:AS];
  assign accSub    = accOffset[AS-1:0];
  assign accHit    = busReq.wr && isGlobal
                     && (offset >= dcie_pkg::OFF_ACCESS)
                     && (accRegion < (OW-AS)'(NUM_REGIONS));

  // completion codes set, clear words retire only visible bits
  assign setVec = transfer_completion_code.valid ? (NC'(1) << transfer_completion_code.code) : '0;
  assign clrVec = {wrClrHi ? (busReq.wdata & viewHi)
                           : dcie_pkg::ZERO_WORD,
                   wrClrLo ? (busReq.wdata & viewLo)
                           : dcie_pkg::ZERO_WORD};

  // set wins over a clear landing in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~clrVec) | setVec;
    end
  end

  assign pendLo = pending[W-1:0];
  assign pendHi = pending[NC-1:W];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= '0;
    end else begin
      if (wrEnLo) begin
        enable[W-1:0] <= (enable[W-1:0] & ~viewLo)
                         | (busReq.wdata & viewLo);
      end
      if (wrEnHi) begin
        enable[NC-1:W] <= (enable[NC-1:W] & ~viewHi)
                          | (busReq.wdata & viewHi);
      end
    end
  end

  // bit n of the write steers channel n only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      quickChannelEnable <= '0;
    end else if (wrQuick) begin
      quickChannelEnable <= (quickChannelEnable & ~quickView)
        | (busReq.wdata[NUM_QCH-1:0] & quickView);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaAccess   <= '0;
      quickAccess <= '0;
    end else if (accHit) begin
      for (int r = 0; r < NUM_REGIONS; r++) begin
        if (accRegion == (OW-AS)'(r)) begin
          unique case (accSub)
            dcie_pkg::SUB_DMA_LO: dmaAccess[r][W-1:0]  <= busReq.wdata;
            dcie_pkg::SUB_DMA_HI: dmaAccess[r][NC-1:W] <= busReq.wdata;
            dcie_pkg::SUB_QUICK:  quickAccess[r] <= busReq.wdata[NUM_QCH-1:0];
            default: ;
          endcase
        end
      end
    end
  end

  // one evaluator for the global range, one per shadow region
  assign evalSel[0]     = evalWrite && isGlobal;
  assign pendEnabled[0] = |(pending & enable);
  assign pendAny[0]     = |pending;

  for (genvar r = 0; r < NUM_REGIONS; r++) begin : g_shadow
    assign evalSel[r+1]     = evalWrite && isShadow
                              && (shadowIdx == RW'(r));
    assign pendEnabled[r+1] = |(pending & enable & dmaAccess[r]);
    assign pendAny[r+1]     = |(pending & dmaAccess[r]);
  end

  for (genvar i = 0; i < NR1; i++) begin : g_reevaluate_trigger_bit
    dcie_region_irq u_region_irq (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .pendEnabled (pendEnabled[i]),
      .pendAny     (pendAny[i]),
      .evalStrobe  (evalSel[i]),
      .irqPulse    (irqPulse[i])
    );
  end

  assign globalCompletionIrq = irqPulse[0];
  assign regionCompletionIrq = irqPulse[NR1-1:1];

  // housekeeping events: overrun, useless evaluate, masked shadow write
  always_comb begin
    events = '0;
    events[dcie_pkg::ST_LOST] = transfer_completion_code.valid && pending[transfer_completion_code.code]
                                && !clrVec[transfer_completion_code.code];
    events[dcie_pkg::ST_REEVALUATE_TRIGGER_BIT_IDLE] = |(evalSel & ~pendEnabled);
    events[dcie_pkg::ST_DENIED] = isShadow && (
      ((wrEnLo || wrClrLo) && |(busReq.wdata & ~viewLo)) ||
      ((wrEnHi || wrClrHi) && |(busReq.wdata & ~viewHi)) ||
      (wrQuick && |(busReq.wdata[NUM_QCH-1:0] & ~quickView)));
  end

  assign statusClr = wrStatus ? busReq.wdata[SW-1:0] : '0;

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~statusClr) | events;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (wrMask) begin
      mask <= busReq.wdata[SW-1:0];
    end
  end

  // registered, so it trails the status bit by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(status & mask);
    end
  end

  // shadow reads see only their enabled bits; write-only words read zero
  always_comb begin
    readWord = dcie_pkg::ZERO_WORD;
    if (inRange) begin
      unique case (offset)
        dcie_pkg::OFF_PEND_LO:  readWord = pendLo & viewLo;
        dcie_pkg::OFF_PEND_HI:  readWord = pendHi & viewHi;
        dcie_pkg::OFF_EN_LO:    readWord = enable[W-1:0] & viewLo;
        dcie_pkg::OFF_EN_HI:    readWord = enable[NC-1:W] & viewHi;
        dcie_pkg::OFF_QUICK_EN:
          readWord[NUM_QCH-1:0] = quickChannelEnable & quickView;
        dcie_pkg::OFF_IRQ_STATUS:
          readWord[SW-1:0] = isGlobal ? status : '0;
        dcie_pkg::OFF_IRQ_MASK:
          readWord[SW-1:0] = isGlobal ? mask : '0;
        default: ;
      endcase
    end
    if (isGlobal && (offset >= dcie_pkg::OFF_ACCESS)
        && (accRegion < (OW-AS)'(NUM_REGIONS))) begin
      for (int r = 0; r < NUM_REGIONS; r++) begin
        if (accRegion == (OW-AS)'(r)) begin
          unique case (accSub)
            dcie_pkg::SUB_DMA_LO: readWord = dmaAccess[r][W-1:0];
            dcie_pkg::SUB_DMA_HI: readWord = dmaAccess[r][NC-1:W];
            dcie_pkg::SUB_QUICK:  readWord[NUM_QCH-1:0] = quickAccess[r];
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdata <= dcie_pkg::ZERO_WORD;
    end else begin
      busRdata <= busReq.rd ? readWord : dcie_pkg::ZERO_WORD;
    end
  end

  code_sets_pending_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    transfer_completion_code.valid |=> pending[$past(transfer_completion_code.code)])
    else $error("completion code did not set its pending bit");

  clear_low_word_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wrClrLo && isGlobal && !transfer_completion_code.valid
    |=> ((pendLo & $past(busReq.wdata)) == '0)
        && ((pendLo & ~$past(busReq.wdata))
            == ($past(pendLo) & ~$past(busReq.wdata))))
    else $error("low clear word misapplied");

  clear_high_word_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wrClrHi && isGlobal && !transfer_completion_code.valid
    |=> ((pendHi & $past(busReq.wdata)) == '0)
        && ((pendHi & ~$past(busReq.wdata))
            == ($past(pendHi) & ~$past(busReq.wdata))))
    else $error("high clear word misapplied");

  shadow_reevaluate_trigger_bit_free_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    evalWrite && isShadow && |(evalSel & pendEnabled)
    |=> |regionCompletionIrq)
    else $error("shadow evaluate write was blocked");

  global_reevaluate_trigger_bit_pulse_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    evalWrite && isGlobal && pendEnabled[0] |=> globalCompletionIrq)
    else $error("global evaluate did not pulse global interrupt");

  quick_bit_map_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wrQuick && isGlobal
    |=> quickChannelEnable == $past(busReq.wdata[NUM_QCH-1:0]))
    else $error("quick channel bit not mapped to its channel");

  quick_shadow_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wrQuick && isShadow
    |=> (quickChannelEnable & ~$past(quickView))
        == ($past(quickChannelEnable) & ~$past(quickView)))
    else $error("shadow write passed a disabled quick channel");

endmodule

`default_nettype wire

//--- include/dcie_pkg.sv
package dcie_pkg;

  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 12;
  localparam int CODE_W    = 6;
  localparam int NUM_CODES = 64;
  localparam int OFF_W     = 8;
  localparam int REGION_W  = ADDR_W - OFF_W;

  // region field 0 is the global range, 1..N are shadow regions 0..N-1
  localparam logic [REGION_W-1:0] GLOBAL_REGION = 4'h0;
  localparam logic [REGION_W-1:0] SHADOW_FIRST  = 4'h1;

  localparam logic [OFF_W-1:0] OFF_PEND_LO    = 8'h00;
  localparam logic [OFF_W-1:0] OFF_PEND_HI    = 8'h04;
  localparam logic [OFF_W-1:0] OFF_EN_LO      = 8'h08;
  localparam logic [OFF_W-1:0] OFF_EN_HI      = 8'h0c;
  localparam logic [OFF_W-1:0] OFF_CLR_LO     = 8'h10;
  localparam logic [OFF_W-1:0] OFF_CLR_HI     = 8'h14;
  localparam logic [OFF_W-1:0] OFF_REEVAL     = 8'h18;
  localparam logic [OFF_W-1:0] OFF_QUICK_EN   = 8'h1c;
  localparam logic [OFF_W-1:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [OFF_W-1:0] OFF_IRQ_MASK   = 8'h24;
  localparam logic [OFF_W-1:0] OFF_ACCESS     = 8'h40;

  // access block per shadow region: stride 16 bytes
  localparam int ACC_SHIFT = 4;
  localparam logic [ACC_SHIFT-1:0] SUB_DMA_LO = 4'h0;
  localparam logic [ACC_SHIFT-1:0] SUB_DMA_HI = 4'h4;
  localparam logic [ACC_SHIFT-1:0] SUB_QUICK  = 4'h8;

  localparam int REEVALUATE_TRIGGER_BIT_BIT      = 0;
  localparam int REEVALUATE_TRIGGER_BIT_RSVD_BIT = 1;

  localparam int STATUS_W     = 3;
  localparam int ST_LOST      = 0;
  localparam int ST_REEVALUATE_TRIGGER_BIT_IDLE = 1;
  localparam int ST_DENIED    = 2;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcie_bus_req_s;

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] code;
  } dcie_tcc_s;

endpackage

//--- core/dcie_region_irq.sv
`timescale 1ns/1ps
`default_nettype none

module dcie_region_irq (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pendEnabled,
  input  wire logic pendAny,
  input  wire logic evalStrobe,
  output logic      irqPulse
);

  logic armed;
  logic fire;

  // a re-evaluate fires even when disarmed, so a missed edge is recovered
  assign fire = pendEnabled && (armed || evalStrobe);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPulse <= 1'b0;
    end else begin
      irqPulse <= fire;
    end
  end

  // rearm only once every pending bit of this view is gone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b1;
    end else if (fire) begin
      armed <= 1'b0;
    end else if (!pendAny) begin
      armed <= 1'b1;
    end
  end

  pulse_one_cycle_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    irqPulse && !evalStrobe |=> !irqPulse)
    else $error("completion pulse longer than one cycle");

  no_rearm_pending_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    irqPulse && pendAny && !evalStrobe
    ##1 (pendAny && !evalStrobe)[*2] |=> !irqPulse)
    else $error("interrupt repeated while pending bits remain");

  reevaluate_trigger_bit_pulses_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    evalStrobe |=> (irqPulse == $past(pendEnabled)))
    else $error("evaluate write did not follow enabled pending state");

endmodule

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                        ref_clk = 1'b0;
  logic                        rst_n   = 1'b0;
  dcie_pkg::dcie_bus_req_s     busReq  = '0;
  dcie_pkg::dcie_tcc_s         transfer_completion_code     = '0;
  logic [dcie_pkg::DATA_W-1:0] busRdata;
  logic [3:0]                  quickChannelEnable;
  logic                        globalCompletionIrq;
  logic [7:0]                  regionCompletionIrq;
  logic                        irqOut;
  int                          fail_count = 0;
  int                          n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  dcie_completion_irq #(
    .NUM_REGIONS(8),
    .NUM_QCH    (4)
  ) i_dcie_completion_irq (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .busReq             (busReq),
    .busRdata           (busRdata),
    .transfer_completion_code                (transfer_completion_code),
    .quickChannelEnable (quickChannelEnable),
    .globalCompletionIrq(globalCompletionIrq),
    .regionCompletionIrq(regionCompletionIrq),
    .irqOut             (irqOut)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // gap cycle after each access keeps one assignment per time step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    busReq <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
    q = busRdata;
  endtask

  task automatic post(input logic [5:0] c);
    @(posedge ref_clk);
    transfer_completion_code <= '{valid: 1'b1, code: c};
    @(posedge ref_clk);
    transfer_completion_code <= '0;
  endtask

  // cycles high over a four-cycle window, global and one region
  task automatic cnt(input int r, output int g, output int rn);
    g  = 0;
    rn = 0;
    repeat (4) begin
      #1;
      if (globalCompletionIrq === 1'b1) g++;
      if (regionCompletionIrq[r] === 1'b1) rn++;
      @(posedge ref_clk);
    end
  endtask

  task automatic t_reset();
    logic [31:0] q;
    chk({22'h0, globalCompletionIrq, regionCompletionIrq, irqOut}, 32'h0);
    rd(12'h000, q); chk(q, 32'h0);
    rd(12'h004, q); chk(q, 32'h0);
    rd(12'h018, q); chk(q, 32'h0);
    rd(12'h0fc, q); chk(q, 32'h0);
    rd(12'hf00, q); chk(q, 32'h0);
  endtask

  task automatic t_pend_clear();
    logic [31:0] q;
    int          g;
    int          rn;
    wr(12'h008, 32'hffffffff);
    wr(12'h00c, 32'hffffffff);
    post(6'd3);
    cnt(0, g, rn); chk(g, 1);
    post(6'd40);
    cnt(0, g, rn); chk(g, 0);
    rd(12'h000, q); chk(q, 32'h8);
    rd(12'h004, q); chk(q, 32'h100);
    wr(12'h010, 32'h0);
    rd(12'h000, q); chk(q, 32'h8);
    wr(12'h014, 32'h100);
    rd(12'h004, q); chk(q, 32'h0);
    rd(12'h000, q); chk(q, 32'h8);
    wr(12'h010, 32'h8);
    rd(12'h000, q); chk(q, 32'h0);
    post(6'd63);
    cnt(0, g, rn); chk(g, 1);
    rd(12'h004, q); chk(q, 32'h80000000);
    wr(12'h014, 32'h80000000);
    rd(12'h004, q); chk(q, 32'h0);
  endtask

  task automatic t_reevaluate_trigger_bit();
    logic [31:0] q;
    int          g;
    int          rn;
    post(6'd5);
    cnt(0, g, rn); chk(g, 1);
    wr(12'h018, 32'h0);
    cnt(0, g, rn); chk(g, 0);
    wr(12'h018, 32'h1);
    cnt(0, g, rn); chk(g, 1);
    wr(12'h040, 32'h20);
    // let any automatic region pulse from the new view pass first
    repeat (4) @(posedge ref_clk);
    wr(12'h118, 32'h1);
    cnt(0, g, rn); chk(rn, 1);
    chk(g, 0);
    wr(12'h020, 32'h7);
    wr(12'h218, 32'h1);
    cnt(1, g, rn); chk(rn, 0);
    rd(12'h020, q); chk(q, 32'h2);
    wr(12'h010, 32'h20);
    wr(12'h018, 32'h1);
    cnt(0, g, rn); chk(g, 0);
  endtask

  task automatic t_quick();
    logic [31:0] q;
    wr(12'h01c, 32'h5);
    #1;
    chk({28'h0, quickChannelEnable}, 32'h5);
    rd(12'h01c, q); chk(q, 32'h5);
    wr(12'h020, 32'h7);
    wr(12'h11c, 32'ha);
    #1;
    chk({28'h0, quickChannelEnable}, 32'h5);
    rd(12'h020, q); chk(q, 32'h4);
    wr(12'h048, 32'h2);
    wr(12'h11c, 32'hf);
    #1;
    chk({28'h0, quickChannelEnable}, 32'h7);
  endtask

  // status bit 2 is still set from the refused shadow write
  task automatic t_irq();
    repeat (2) @(posedge ref_clk);
    #1;
    chk({31'h0, irqOut}, 32'h0);
    wr(12'h024, 32'h4);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({31'h0, irqOut}, 32'h1);
    wr(12'h020, 32'h4);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({31'h0, irqOut}, 32'h0);
  endtask

  // repeat code is lost; a clear meeting a set leaves the bit set
  task automatic t_lost();
    logic [31:0] q;
    int          g;
    int          rn;
    post(6'd7);
    cnt(0, g, rn); chk(g, 1);
    post(6'd7);
    rd(12'h020, q); chk(q, 32'h1);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: 12'h010, wdata: 32'h80};
    transfer_completion_code    <= '{valid: 1'b1, code: 6'd7};
    @(posedge ref_clk);
    busReq <= '0;
    transfer_completion_code    <= '0;
    rd(12'h000, q); chk(q, 32'h80);
    wr(12'h020, 32'h7);
    rd(12'h020, q); chk(q, 32'h0);
    wr(12'h010, 32'h80);
    rd(12'h000, q); chk(q, 32'h0);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_pend_clear();
    t_reevaluate_trigger_bit();
    t_quick();
    t_irq();
    t_lost();
    tally_and_finish();
  end
endmodule

`default_nettype wire
